// ---- inc/alc_pkg.sv ----
package alc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register indices, one byte each
  localparam logic [2:0] ADDR_REG_CTRL = 3'h0;
  localparam logic [2:0] ADDR_SW_LOW = 3'h1;
  localparam logic [2:0] ADDR_SW_HIGH = 3'h2;
  localparam logic [2:0] ADDR_SUPPLY = 3'h3;
  localparam logic [2:0] ADDR_AMP_CTRL = 3'h4;
  localparam logic [2:0] ADDR_OFFSET = 3'h5;
  localparam logic [2:0] ADDR_GAIN_LOW = 3'h6;
  localparam logic [2:0] ADDR_GAIN_HIGH = 3'h7;
  // Field positions
  localparam int REF_LINK_BIT = 7;
  localparam int AMP_EN_BIT = 6;
  localparam int AMP_STAT_BIT = 5;
  localparam int CAL_MODE_BIT = 7;
  // Implemented-bit masks
  localparam logic [7:0] MASK_REG_CTRL = 8'h87;
  localparam logic [7:0] MASK_SW_HIGH = 8'h01;
  localparam logic [7:0] MASK_SUPPLY = 8'h03;
  localparam logic [7:0] MASK_AMP_CTRL = 8'h43;
  localparam logic [7:0] MASK_GAIN_HIGH = 8'h01;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h20;
  typedef enum logic [2:0] {
    ALC_LDO_HIZ = 3'b000,
    ALC_LDO_BYPASS = 3'b001,
    ALC_LDO_2V2 = 3'b010,
    ALC_LDO_2V5 = 3'b011,
    ALC_LDO_3V0 = 3'b110
  } alc_ldo_mode_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } alc_bus_req_t;
  typedef struct packed {
    alc_ldo_mode_t ldo_mode;
    logic ldo_on;
    logic reference_link_switch;
    logic [8:0] path_switch;
    logic [1:0] supply_select;
    logic amp_enable;
    logic [1:0] amp_bandwidth_field;
    logic calibration_mode_select;
    logic [6:0] offset_code;
    logic [8:0] gain_code;
  } alc_ctrl_t;
endpackage

// ---- rtl/alc_regs.sv ----
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Mode x00 hi-z off, x01 bypass off
// - Mode 010 2.2V, 011 2.5V, 11x 3.0V
// - Regulator bit 7 closes reference link switch
// - Regulator bits 6..3 read zero
// - Nine path bits close switches when one
// - Path high bits 7..1 read zero
// - Supply bits pick regulator when one
// - Amp control bit 6 enables amplifier
// - Output status bit is read only
// - Calibration mode: status follows amplifier output
// - Normal mode: status reads zero
// - Bandwidth field selects four bandwidths
// - Offset bit 7 selects calibration mode
module alc_regs
  import alc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire alc_bus_req_t req,
  output alc_ctrl_t ctrl,
  output logic [7:0] rdata,
  // Analog status
  input wire logic amp_out_raw
);
  logic [7:0] reg_ctrl, sw_low, sw_high, supply, amp_ctrl, offset, gain_low, gain_high;
  logic amp_sync1, amp_sync2;
  logic stat;
  alc_ctrl_t next_ctrl;
  logic [7:0] next_rdata;
  wire cal_mode = offset[CAL_MODE_BIT];
  wire [7:0] amp_read = (amp_ctrl & MASK_AMP_CTRL) | ({7'h00, stat} << AMP_STAT_BIT);
  wire [2:0] mode = reg_ctrl[2:0];
  alc_ldo_mode_t next_mode;

  // Decode mode: top bit ignored when low bits are x0x with bit1 clear
  always_comb begin
    case (mode)
      3'b000, 3'b100: next_mode = ALC_LDO_HIZ;
      3'b001, 3'b101: next_mode = ALC_LDO_BYPASS;
      3'b010: next_mode = ALC_LDO_2V2;
      3'b011: next_mode = ALC_LDO_2V5;
      3'b110, 3'b111: next_mode = ALC_LDO_3V0;
      default: next_mode = ALC_LDO_HIZ;
    endcase
  end

  always_comb begin
    next_ctrl.ldo_mode = next_mode;
    next_ctrl.ldo_on = mode[1];
    next_ctrl.reference_link_switch = reg_ctrl[REF_LINK_BIT];
    next_ctrl.path_switch = {sw_high[0], sw_low};
    next_ctrl.supply_select = supply[1:0];
    next_ctrl.amp_enable = amp_ctrl[AMP_EN_BIT];
    next_ctrl.amp_bandwidth_field = amp_ctrl[1:0];
    next_ctrl.calibration_mode_select = cal_mode;
    next_ctrl.offset_code = offset[6:0];
    next_ctrl.gain_code = {gain_high[0], gain_low};
  end

  // Read selection; reserved bits always come back as zero
  wire [7:0] read_reg_ctrl = reg_ctrl & MASK_REG_CTRL;
  wire [7:0] read_sw_high = sw_high & MASK_SW_HIGH;
  wire [7:0] read_supply = supply & MASK_SUPPLY;
  wire [7:0] read_gain_high = gain_high & MASK_GAIN_HIGH;
  assign next_rdata = (req.addr == ADDR_REG_CTRL) ? read_reg_ctrl :
    (req.addr == ADDR_SW_LOW) ? sw_low :
    (req.addr == ADDR_SW_HIGH) ? read_sw_high :
    (req.addr == ADDR_SUPPLY) ? read_supply :
    (req.addr == ADDR_AMP_CTRL) ? amp_read :
    (req.addr == ADDR_OFFSET) ? offset :
    (req.addr == ADDR_GAIN_LOW) ? gain_low :
    read_gain_high;

  // Amplifier output crosses in through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      amp_sync1 <= 1'b0;
      amp_sync2 <= 1'b0;
      stat <= 1'b0;
    end else begin
      amp_sync1 <= amp_out_raw;
      amp_sync2 <= amp_sync1;
      stat <= cal_mode & amp_sync2;
    end
  end

  // Regulator mode and reference link
  alc_byte_reg #(
    .INDEX(ADDR_REG_CTRL),
    .MASK(MASK_REG_CTRL),
    .RESET_VALUE(RST_ZERO)
  ) u_reg_ctrl (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(reg_ctrl)
  );

  // Path switches, low eight
  alc_byte_reg #(
    .INDEX(ADDR_SW_LOW),
    .RESET_VALUE(RST_ZERO)
  ) u_sw_low (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(sw_low)
  );

  // Path switch, ninth
  alc_byte_reg #(
    .INDEX(ADDR_SW_HIGH),
    .MASK(MASK_SW_HIGH),
    .RESET_VALUE(RST_ZERO)
  ) u_sw_high (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(sw_high)
  );

  // Amplifier supply selection
  alc_byte_reg #(
    .INDEX(ADDR_SUPPLY),
    .MASK(MASK_SUPPLY),
    .RESET_VALUE(RST_ZERO)
  ) u_supply (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(supply)
  );

  // Amplifier control; status position is never stored
  alc_byte_reg #(
    .INDEX(ADDR_AMP_CTRL),
    .MASK(MASK_AMP_CTRL),
    .RESET_VALUE(RST_ZERO)
  ) u_amp_ctrl (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(amp_ctrl)
  );

  // Offset trim and calibration mode
  alc_byte_reg #(
    .INDEX(ADDR_OFFSET),
    .RESET_VALUE(RST_OFFSET)
  ) u_offset (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(offset)
  );

  // Gain resistor, low eight
  alc_byte_reg #(
    .INDEX(ADDR_GAIN_LOW),
    .RESET_VALUE(RST_ZERO)
  ) u_gain_low (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(gain_low)
  );

  // Gain resistor, ninth
  alc_byte_reg #(
    .INDEX(ADDR_GAIN_HIGH),
    .MASK(MASK_GAIN_HIGH),
    .RESET_VALUE(RST_ZERO)
  ) u_gain_high (
    .mclk(mclk),
    .rst_n(rst_n),
    .req(req),
    .value(gain_high)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      rdata <= RST_ZERO;
    end else begin
      ctrl <= next_ctrl;
      rdata <= req.rd ? next_rdata : RST_ZERO;
    end
  end

  status_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cal_mode |=> !stat) else $error("status not zero in normal mode");
  status_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cal_mode && $stable(cal_mode) |=> stat == $past(amp_sync2))
    else $error("status not following amplifier");
  mode_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[2:1] == 2'b11 |=> ctrl.ldo_mode == ALC_LDO_3V0)
    else $error("mode 11x not decoded");
  hiz_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[1:0] == 2'b00 |=> ctrl.ldo_mode == ALC_LDO_HIZ && !ctrl.ldo_on)
    else $error("mode x00 not decoded");
  link_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_REG_CTRL |=> ##1 ctrl.reference_link_switch == $past(req.wdata[7], 2))
    else $error("reference link not updated");
  reserved_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_REG_CTRL |=> rdata[6:3] == 4'h0)
    else $error("regulator reserved bits nonzero");
  high_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_SW_HIGH |=> rdata[7:1] == 7'h00)
    else $error("path high reserved bits nonzero");
  supply_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_SUPPLY |=> rdata[7:2] == 6'h00)
    else $error("supply reserved bits nonzero");
  enable_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_AMP_CTRL |=> ##1 ctrl.amp_enable == $past(req.wdata[6], 2))
    else $error("amplifier enable not updated");
  status_ro_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_AMP_CTRL |=> !amp_ctrl[AMP_STAT_BIT])
    else $error("status bit was written");
  path_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req.wr && req.addr == ADDR_SW_LOW) |=> $stable(sw_low))
    else $error("path switches changed without write");
  bypass_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[1:0] == 2'b01 |=> ctrl.ldo_mode == ALC_LDO_BYPASS && !ctrl.ldo_on)
    else $error("mode x01 not decoded");
  low_volt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[2:0] == 3'b010 |=> ctrl.ldo_mode == ALC_LDO_2V2 && ctrl.ldo_on)
    else $error("mode 010 not decoded");
  mid_volt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[2:0] == 3'b011 |=> ctrl.ldo_mode == ALC_LDO_2V5 && ctrl.ldo_on)
    else $error("mode 011 not decoded");
  path_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_SW_LOW |=> ##1 ctrl.path_switch[7:0] == $past(req.wdata, 2))
    else $error("low path switches not updated");
  path_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_SW_HIGH |=> ##1 ctrl.path_switch[8] == $past(req.wdata[0], 2))
    else $error("ninth path switch not updated");
  supply_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_SUPPLY |=> ##1 ctrl.supply_select == $past(req.wdata[1:0], 2))
    else $error("supply select not updated");
  bandwidth_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_AMP_CTRL |=> ##1
    ctrl.amp_bandwidth_field == $past(req.wdata[1:0], 2))
    else $error("bandwidth not updated");
  cal_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_OFFSET |=> ##1 ctrl.calibration_mode_select == $past(req.wdata[7], 2))
    else $error("calibration mode not updated");
  amp_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_AMP_CTRL |=> !rdata[7] && rdata[4:2] == 3'h0)
    else $error("amplifier reserved bits nonzero");
  status_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.rd && req.addr == ADDR_AMP_CTRL |=> rdata[AMP_STAT_BIT] == $past(stat))
    else $error("status bit not read back");
  ctrl_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req.wr && req.addr == ADDR_REG_CTRL) |=> $stable(reg_ctrl))
    else $error("regulator control changed without write");
  supply_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req.wr && req.addr == ADDR_SUPPLY) |=> $stable(supply))
    else $error("supply select changed without write");
  offset_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_OFFSET |=> ##1 ctrl.offset_code == $past(req.wdata[6:0], 2))
    else $error("offset code not updated");
  gain_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req.wr && req.addr == ADDR_GAIN_LOW |=> ##1 ctrl.gain_code[7:0] == $past(req.wdata, 2))
    else $error("gain code not updated");
  reg_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_ctrl[6:3] == 4'h0)
    else $error("regulator reserved bits stored");
endmodule

// One register byte; unimplemented bits are dropped on write
module alc_byte_reg
  import alc_pkg::*;
#(
  parameter logic [2:0] INDEX = 3'h0,
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire alc_bus_req_t req,
  // Stored byte
  output logic [7:0] value
);
  wire hit = req.wr && (req.addr == INDEX);
  wire [7:0] next_value = hit ? (req.wdata & MASK) : value;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end
endmodule

// ---- verif/alc_regs_tb_top.sv ----
`timescale 1ns/100ps
module alc_regs_tb_top
  import alc_pkg::*;
;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} alc_row_t;
  logic mclk;
  logic rst_n;
  logic amp_out_raw;
  alc_bus_req_t req;
  alc_ctrl_t ctrl;
  logic [7:0] rdata;
  int error_cnt;
  int samples_checked;
  int cyc;
  // Write, then read back: address, written value, value read back
  alc_row_t rows[9] = '{'{3'h0, 8'hFF, 8'h87}, '{3'h0, 8'h03, 8'h03}, '{3'h1, 8'hA5, 8'hA5},
    '{3'h2, 8'hFF, 8'h01}, '{3'h3, 8'hFF, 8'h03}, '{3'h4, 8'hFF, 8'h43},
    '{3'h5, 8'h7F, 8'h7F}, '{3'h6, 8'h3C, 8'h3C}, '{3'h7, 8'hFE, 8'h00}};
  alc_regs dut (.mclk(mclk), .rst_n(rst_n), .req(req), .ctrl(ctrl), .rdata(rdata),
    .amp_out_raw(amp_out_raw));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task chk(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 q = rdata;
  endtask
  task settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  function automatic logic [2:0] mode_of(input logic [2:0] c);
    if (c[1:0] == 2'b00) return 3'b000;
    if (c[1:0] == 2'b01) return 3'b001;
    return c[2] ? 3'b110 : c;
  endfunction
  task print_verdict();
    $display("Counts: checked=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] q;
    req = '0;
    amp_out_raw = 1'b0;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), q);
      chk(9'(q), (a == 5) ? 9'h020 : 9'h000);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, q);
      chk(9'(q), 9'(rows[i].e));
    end
    chk(ctrl.path_switch, 9'h1A5);
    chk(9'(ctrl.offset_code), 9'h07F);
    chk(ctrl.gain_code, 9'h03C);
    chk(9'(ctrl.supply_select), 9'h003);
    for (int m = 0; m < 16; m++) begin
      wr(ADDR_REG_CTRL, {m[3], 4'h0, m[2:0]});
      settle();
      chk(9'(ctrl.ldo_mode), 9'(mode_of(m[2:0])));
      chk(9'(ctrl.ldo_on), 9'(m[1]));
      chk(9'(ctrl.reference_link_switch), 9'(m[3]));
    end
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_AMP_CTRL, {2'b01, 4'h0, b[1:0]});
      settle();
      chk(9'(ctrl.amp_bandwidth_field), 9'(b[1:0]));
      chk(9'(ctrl.amp_enable), 9'h001);
    end
    wr(ADDR_AMP_CTRL, 8'h00);
    settle();
    chk(9'(ctrl.amp_enable), 9'h000);
    @(posedge mclk);
    amp_out_raw <= 1'b1;
    wr(ADDR_OFFSET, 8'h80);
    settle();
    chk(9'(ctrl.calibration_mode_select), 9'h001);
    rd(ADDR_AMP_CTRL, q);
    chk(9'(q), 9'h020);
    amp_out_raw <= 1'b0;
    settle();
    rd(ADDR_AMP_CTRL, q);
    chk(9'(q), 9'h000);
    amp_out_raw <= 1'b1;
    wr(ADDR_OFFSET, 8'h00);
    settle();
    rd(ADDR_AMP_CTRL, q);
    chk(9'(q), 9'h000);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk(ctrl.path_switch, 9'h000);
    chk(9'(rdata), 9'h000);
    repeat (9) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    chk(9'(ctrl.offset_code), 9'h020);
    chk(9'(ctrl.calibration_mode_select), 9'h000);
    rd(ADDR_SW_HIGH, q);
    chk(9'(q), 9'h000);
    print_verdict();
  end
endmodule
